/* clk_gate_pkg.sv */
// Constants for the peripheral clock gate and watchdog mode block
package clk_gate_pkg;
    // Bus geometry
    localparam int          ADDR_W         = 10;
    localparam int          DATA_W         = 32;
    localparam int          REG_W          = 16;
    // Register indices (word offsets within the system control page)
    localparam logic [7:0]  IDX_PRESC      = 8'h1a;
    localparam logic [7:0]  IDX_PERIPH     = 8'h1c;
    localparam logic [7:0]  IDX_SYSCTL     = 8'h22;
    // Byte addresses are four times the index
    localparam logic [ADDR_W-1:0] ADDR_PRESC  = {IDX_PRESC, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PERIPH = {IDX_PERIPH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SYSCTL = {IDX_SYSCTL, 2'b00};
    // Peripheral clock enable field positions
    localparam int          POS_EVMGR_A    = 0;
    localparam int          POS_EVMGR_B    = 1;
    localparam int          POS_CONVERTER  = 3;
    localparam int          POS_SERIAL_P   = 8;
    localparam int          POS_ASYNC_A    = 10;
    localparam int          POS_ASYNC_B    = 11;
    localparam int          POS_BUF_PORT   = 12;
    localparam int          POS_CAN        = 14;
    // Writable enable bits; all others read as zero
    localparam logic [15:0] PERIPH_MASK    = 16'h5d0b;
    localparam logic [15:0] PERIPH_RESET   = 16'h0000;
    // System control field positions and reset values
    localparam int          POS_WD_UNLOCK  = 0;
    localparam int          POS_WD_IRQSEL  = 1;
    localparam logic        WD_UNLOCK_RST  = 1'b1;
    localparam logic        WD_IRQSEL_RST  = 1'b0;
    // Prescaler field
    localparam int          PRESC_W        = 3;
    localparam logic [2:0]  PRESC_RESET    = 3'h1;
    localparam int          DIVCNT_W       = 4;
    // Number of gated clock outputs
    localparam int          NUM_GATES      = 8;
    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_type;
endpackage

/* clk_gate_ctrl.sv */
// Peripheral clock gating, fast prescaler and watchdog mode control over APB
//
// Summary of operation
// RQ1: Bits 0,1 gate fast clock to event managers
// RQ2: Bit 3 gates fast clock to converter
// RQ3: Bit 8 gates slow clock to serial periph
// RQ4: Bit 10 gates slow clock to async A
// RQ5: Bit 11 gates slow clock to async B
// RQ6: Bit 12 gates slow clock to buffered port
// RQ7: Bit 14 gates system clock to CAN
// RQ8: All clock enables clear on reset
// RQ9: Unlock bit set permits watchdog disable changes
// RQ10: Writing one clears unlock; zero ignored
// RQ11: Unlock stays clear until reset; readable
// RQ12: Select bit routes watchdog to irq or reset
// RQ13: Select bit resets to zero, reset active
// RQ14: Three-bit prescaler field, resets to 001
// RQ15: Fast clock is system clock/2 after reset
// RQ16: Writes accepted only while protected unlock asserted
// RQ17: Code n divides by 2n, zero passes
// RQ18: Reserved bits read zero, ignore writes
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module clk_gate_ctrl
    import clk_gate_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rstn_in,
    // APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0] pwdata_in,
    output logic                   pready_out,
    output logic      [DATA_W-1:0] prdata_out,
    output logic                   pslverr_out,
    // Processor protected-register window
    input  wire logic              protected_write_unlock_in,
    // Slow peripheral clock tick from its own prescaler
    input  wire logic              slow_periph_tick_in,
    // Watchdog expiry pulse from the watchdog counter
    input  wire logic              wd_expire_in,
    // Fast peripheral clock tick, ungated
    output logic                   fast_periph_tick_out,
    // Gated peripheral clock ticks
    output logic                   evmgr_a_clk_out,
    output logic                   evmgr_b_clk_out,
    output logic                   converter_clk_out,
    output logic                   serial_periph_clk_out,
    output logic                   async_serial_a_clk_out,
    output logic                   async_serial_b_clk_out,
    output logic                   buffered_port_clk_out,
    output logic                   can_ctrl_clk_out,
    // Watchdog mode outputs
    output logic                   wd_disable_unlock_out,
    output logic                   wd_reset_out,
    output logic                   wd_irq_out
);

    // Complete state of the block
    typedef struct packed {
        bus_state_type        bus_st;     // Bus handshake state
        logic [DATA_W-1:0]    rdata;      // Captured read data
        logic                 err;        // Captured error answer
        logic [15:0]          clk_en;     // Peripheral clock enables
        logic                 wd_unlock;  // Watchdog disable unlock
        logic                 wd_irqsel;  // Watchdog irq select
        logic [PRESC_W-1:0]   presc;      // Fast prescaler code
        logic [DIVCNT_W-1:0]  div_cnt;    // Fast divider counter
        logic                 fast_tick;  // Fast clock tick
        logic [NUM_GATES-1:0] gated;      // Gated ticks
        logic                 wd_rst;     // Watchdog reset output
        logic                 wd_irq;     // Watchdog irq output
    } state_type;

    state_type state_r;                  // Registered state
    state_type state_nxt;                // Next state

    // Decode and access helpers
    logic                   access;      // Access phase present
    logic                   hit_periph;  // Enable register addressed
    logic                   hit_sysctl;  // System control addressed
    logic                   hit_presc;   // Prescaler addressed
    logic                   mapped;      // Any register addressed
    logic                   wr_ok;       // Write commits this edge
    logic [DATA_W-1:0]      rd_mux;      // Read value before capture
    logic [DIVCNT_W-1:0]    div_last;    // Last count of fast period
    logic                   fast_tick_nxt; // Fast tick due at this edge
    logic [NUM_GATES-1:0]   gate_src;    // Tick source per gate
    logic [NUM_GATES-1:0]   gate_en;     // Enable per gate

    // Address decode; only whole-word addresses match
    assign access     = psel_in && penable_in;
    assign hit_periph = (paddr_in == ADDR_PERIPH);
    assign hit_sysctl = (paddr_in == ADDR_SYSCTL);
    assign hit_presc  = (paddr_in == ADDR_PRESC);
    assign mapped     = hit_periph || hit_sysctl || hit_presc;
    // Writes land only at the edge where pready is seen high
    assign wr_ok = access && pwrite_in && (state_r.bus_st == BUS_DONE) && mapped
                   && protected_write_unlock_in; // RQ16

    // Read mux; reserved bits forced to zero
    always_comb begin
        rd_mux = '0;
        if (hit_periph) begin
            rd_mux[15:0] = state_r.clk_en & PERIPH_MASK; // RQ18
        end else if (hit_sysctl) begin
            rd_mux[POS_WD_UNLOCK] = state_r.wd_unlock; // RQ11
            rd_mux[POS_WD_IRQSEL] = state_r.wd_irqsel;
        end else if (hit_presc) begin
            rd_mux[PRESC_W-1:0] = state_r.presc;
        end
    end

    // Final count of one fast period: 2n-1, zero for pass-through
    assign div_last = (state_r.presc == 3'h0) ? 4'h0
                    : DIVCNT_W'({state_r.presc, 1'b0} - 4'h1); // RQ17

    // Kept apart from the state copy so the gates do not loop back through it
    assign fast_tick_nxt = (state_r.div_cnt >= div_last); // RQ17

    // Map each gate to its tick source and enable bit
    generate
        for (genvar g = 0; g < NUM_GATES; g++) begin : g_gate
            localparam int POS = (g == 0) ? POS_EVMGR_A  : (g == 1) ? POS_EVMGR_B :
                                 (g == 2) ? POS_CONVERTER : (g == 3) ? POS_SERIAL_P :
                                 (g == 4) ? POS_ASYNC_A  : (g == 5) ? POS_ASYNC_B :
                                 (g == 6) ? POS_BUF_PORT : POS_CAN;
            // Fast tick for first three, slow tick next four, system clock last
            if (g < 3) begin : g_fast
                assign gate_src[g] = fast_tick_nxt; // RQ1 RQ2
            end else if (g < 7) begin : g_slow
                assign gate_src[g] = slow_periph_tick_in; // RQ3 RQ4 RQ5 RQ6
            end else begin : g_sys
                assign gate_src[g] = 1'b1; // RQ7
            end
            assign gate_en[g] = state_r.clk_en[POS];
        end
    endgenerate

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        // Bus handshake: one wait cycle so read data comes from a flop
        case (state_r.bus_st)
            BUS_IDLE: begin
                if (access) begin
                    state_nxt.bus_st = BUS_DONE;
                    state_nxt.rdata  = pwrite_in ? '0 : rd_mux;
                    // Unmapped address, or write outside the protected window
                    state_nxt.err    = !mapped || (pwrite_in && !protected_write_unlock_in); // RQ16
                end
            end
            BUS_DONE: begin
                state_nxt.bus_st = BUS_IDLE;
                state_nxt.err    = 1'b0;
            end
            default: begin
                state_nxt.bus_st = BUS_IDLE;
            end
        endcase
        // Register writes
        if (wr_ok && hit_periph) begin
            state_nxt.clk_en = pwdata_in[15:0] & PERIPH_MASK; // RQ8 RQ18
        end
        if (wr_ok && hit_sysctl) begin
            // One clears the unlock, zero leaves it; never set by software
            if (pwdata_in[POS_WD_UNLOCK]) begin
                state_nxt.wd_unlock = 1'b0; // RQ10 RQ11
            end
            state_nxt.wd_irqsel = pwdata_in[POS_WD_IRQSEL]; // RQ12
        end
        if (wr_ok && hit_presc) begin
            state_nxt.presc = pwdata_in[PRESC_W-1:0]; // RQ14
        end
        // Fast divider; a code change takes effect within the current period
        if (fast_tick_nxt) begin
            state_nxt.div_cnt   = '0;
            state_nxt.fast_tick = 1'b1; // RQ15 RQ17
        end else begin
            state_nxt.div_cnt   = state_r.div_cnt + 4'h1;
            state_nxt.fast_tick = 1'b0;
        end
        // Gated ticks follow the enable bits
        state_nxt.gated  = gate_src & gate_en;
        // Watchdog expiry routed by the select bit
        state_nxt.wd_rst = wd_expire_in && !state_r.wd_irqsel; // RQ12 RQ13
        state_nxt.wd_irq = wd_expire_in && state_r.wd_irqsel; // RQ12
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state_r           <= '0;
            state_r.bus_st    <= BUS_IDLE;
            state_r.clk_en    <= PERIPH_RESET; // RQ8
            state_r.wd_unlock <= WD_UNLOCK_RST; // RQ11
            state_r.wd_irqsel <= WD_IRQSEL_RST; // RQ13
            state_r.presc     <= PRESC_RESET; // RQ14 RQ15
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs
    assign pready_out             = (state_r.bus_st == BUS_DONE);
    assign prdata_out             = state_r.rdata;
    assign pslverr_out            = state_r.err;
    assign fast_periph_tick_out   = state_r.fast_tick;
    assign evmgr_a_clk_out        = state_r.gated[0];
    assign evmgr_b_clk_out        = state_r.gated[1];
    assign converter_clk_out      = state_r.gated[2];
    assign serial_periph_clk_out  = state_r.gated[3];
    assign async_serial_a_clk_out = state_r.gated[4];
    assign async_serial_b_clk_out = state_r.gated[5];
    assign buffered_port_clk_out  = state_r.gated[6];
    assign can_ctrl_clk_out       = state_r.gated[7];
    assign wd_disable_unlock_out  = state_r.wd_unlock; // RQ9
    assign wd_reset_out           = state_r.wd_rst;
    assign wd_irq_out             = state_r.wd_irq;

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    // Event manager A tick only from its bit and a fast tick
    ev_a_gate_a: assert property (evmgr_a_clk_out |-> $past(state_r.clk_en[POS_EVMGR_A]) && fast_periph_tick_out) // RQ1
        else $error("event manager A clock without enable");
    // Converter tick follows enable and fast tick
    conv_gate_a: assert property (state_r.clk_en[POS_CONVERTER] && fast_tick_nxt
                                  && !(wr_ok && hit_periph) |=> converter_clk_out) // RQ2
        else $error("converter clock missing");
    // Serial periph gate passes slow tick
    spi_gate_a: assert property (serial_periph_clk_out == $past(slow_periph_tick_in && state_r.clk_en[POS_SERIAL_P])) // RQ3
        else $error("serial periph clock wrong");
    // Async A gate
    async_a_gate_a: assert property (async_serial_a_clk_out
                                     == $past(slow_periph_tick_in && state_r.clk_en[POS_ASYNC_A])) // RQ4
        else $error("async A clock wrong");
    // Async B gate
    async_b_gate_a: assert property (async_serial_b_clk_out
                                     == $past(slow_periph_tick_in && state_r.clk_en[POS_ASYNC_B])) // RQ5
        else $error("async B clock wrong");
    // Buffered port gate
    buf_port_gate_a: assert property (buffered_port_clk_out
                                      == $past(slow_periph_tick_in && state_r.clk_en[POS_BUF_PORT])) // RQ6
        else $error("buffered port clock wrong");
    // CAN gets every system cycle while enabled
    can_gate_a: assert property (can_ctrl_clk_out == $past(state_r.clk_en[POS_CAN])) // RQ7
        else $error("CAN clock wrong");
    // Enables start off after reset
    en_reset_a: assert property ($rose(rstn_in) |-> state_r.clk_en == 16'h0000) // RQ8
        else $error("clock enables not cleared by reset");
    // Unlock never rises outside reset
    unlock_sticky_a: assert property (!state_r.wd_unlock |=> !state_r.wd_unlock) // RQ10 RQ11
        else $error("watchdog unlock came back");
    // Writing one to unlock clears it on the next cycle
    unlock_clear_a: assert property (wr_ok && hit_sysctl && pwdata_in[POS_WD_UNLOCK]
                                     |=> !wd_disable_unlock_out) // RQ10
        else $error("unlock not cleared");
    // Reset and irq outputs are exclusive and follow the select bit
    wd_route_a: assert property (wd_expire_in |=> (wd_irq_out == $past(state_r.wd_irqsel))
                                 && (wd_reset_out == !$past(state_r.wd_irqsel))) // RQ12
        else $error("watchdog routing wrong");
    // After reset: reset output selected, divide by two
    reset_mode_a: assert property ($rose(rstn_in) |-> !state_r.wd_irqsel && state_r.presc == 3'h1) // RQ13 RQ14
        else $error("reset values wrong");
    // Code one gives a tick every second cycle
    half_rate_a: assert property (fast_periph_tick_out && state_r.presc == 3'h1 && !(wr_ok && hit_presc)
                                  |=> !fast_periph_tick_out ##1 fast_periph_tick_out) // RQ15 RQ17
        else $error("fast clock not system clock over two");
    // No register changes without the protected window
    locked_write_a: assert property (!protected_write_unlock_in |=> $stable(state_r.clk_en)
                                     && $stable(state_r.presc) && $stable(state_r.wd_irqsel)) // RQ16
        else $error("write accepted while locked");
    // Reserved bits never read back; the address is still held while pready stands
    reserved_zero_a: assert property (pready_out && hit_periph |-> prdata_out[31:16] == '0
                                      && (prdata_out[15:0] & ~PERIPH_MASK) == '0) // RQ18
        else $error("reserved bit read as one");
    res_sysctl_a: assert property (pready_out && hit_sysctl |-> prdata_out[31:2] == '0) // RQ18
        else $error("reserved control bit read as one");
    res_presc_a: assert property (pready_out && hit_presc |-> prdata_out[31:3] == '0) // RQ18
        else $error("reserved prescaler bit read as one");

    // Event manager B tick only from its bit and a fast tick
    ev_b_gate_a: assert property (evmgr_b_clk_out |-> $past(state_r.clk_en[POS_EVMGR_B]) && fast_periph_tick_out) // RQ1
        else $error("event manager B clock without enable");
    // Event manager B stays quiet while disabled
    ev_b_off_a: assert property (!state_r.clk_en[POS_EVMGR_B] |=> !evmgr_b_clk_out) // RQ1
        else $error("event manager B clock while off");
    // Converter quiet while disabled
    conv_off_a: assert property (!state_r.clk_en[POS_CONVERTER] |=> !converter_clk_out) // RQ2
        else $error("converter clock while off");
    // Converter ticks only together with the fast tick
    conv_fast_a: assert property (converter_clk_out |-> fast_periph_tick_out) // RQ2
        else $error("converter tick off the fast tick");
    // Buffered port quiet while disabled
    bp_off_a: assert property (!state_r.clk_en[POS_BUF_PORT] |=> !buffered_port_clk_out) // RQ6
        else $error("buffered port clock while off");
    // Enable write stores the masked word
    en_write_a: assert property (wr_ok && hit_periph
                                 |=> state_r.clk_en == $past(pwdata_in[15:0] & PERIPH_MASK)) // RQ8
        else $error("enable write not stored");

    // Writing zero to the unlock leaves it set
    unlock_keep_a: assert property (wr_ok && hit_sysctl && !pwdata_in[POS_WD_UNLOCK] && state_r.wd_unlock
                                    |=> wd_disable_unlock_out) // RQ10
        else $error("unlock cleared by a zero");
    // Select bit takes the written value
    irqsel_write_a: assert property (wr_ok && hit_sysctl
                                     |=> state_r.wd_irqsel == $past(pwdata_in[POS_WD_IRQSEL])) // RQ12
        else $error("select bit not stored");
    // Watchdog outputs never both high
    wd_exclusive_a: assert property (!(wd_irq_out && wd_reset_out)) // RQ12
        else $error("watchdog outputs both high");
    // No watchdog output without an expiry
    wd_quiet_a: assert property (!wd_expire_in |=> !wd_irq_out && !wd_reset_out) // RQ12
        else $error("watchdog output without expiry");

    // Prescaler write stores the low three bits
    presc_write_a: assert property (wr_ok && hit_presc
                                    |=> state_r.presc == $past(pwdata_in[PRESC_W-1:0])) // RQ14
        else $error("prescaler write not stored");
    // Code zero ticks every cycle
    zero_pass_a: assert property (state_r.presc == 3'h0 |=> fast_periph_tick_out) // RQ17
        else $error("code zero does not pass the clock");
    // Nonzero code never ticks twice in a row
    tick_pulse_a: assert property (fast_periph_tick_out && state_r.presc != 3'h0 && !(wr_ok && hit_presc)
                                   |=> !fast_periph_tick_out) // RQ17
        else $error("fast tick longer than one cycle");
    // Divider never counts past the longest period
    div_range_a: assert property (state_r.div_cnt <= 4'hd) // RQ17
        else $error("fast divider out of range");

    // Exactly one wait state before pready
    bus_wait_a: assert property (access && state_r.bus_st == BUS_IDLE |=> pready_out) // RQ16
        else $error("pready not after one wait state");
    // Pready stands a single cycle
    ready_pulse_a: assert property (pready_out |=> !pready_out) // RQ16
        else $error("pready held too long");
    // Locked write answers with an error
    locked_err_a: assert property (access && state_r.bus_st == BUS_IDLE && pwrite_in && !protected_write_unlock_in
                                   |=> pslverr_out) // RQ16
        else $error("locked write not refused");
    // Unmapped address answers with an error and zero data
    unmapped_err_a: assert property (access && state_r.bus_st == BUS_IDLE && !mapped
                                     |=> pslverr_out && prdata_out == '0) // RQ18
        else $error("unmapped access not refused");

endmodule

/* tb_peripheral_clock_gate_and_wd_mode.sv */
// Self-checking testbench for the peripheral clock gate and watchdog mode block
`timescale 1ns/1ps
module tb_peripheral_clock_gate_and_wd_mode;
    import clk_gate_pkg::*;
    // Bench driven inputs
    logic              clk;
    logic              rstn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic              unlock;
    logic              slow_tick;
    logic              wd_exp;
    // Observed outputs
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              fast, ev_a, ev_b, conv, spi, sa, sb, bp, can;
    logic              wd_unl, wd_rst, wd_irq;
    // Scoreboard state
    int                errors;
    int                comparisons;
    int                cnt[9];
    logic [DATA_W-1:0] rd;
    logic              err;
    localparam logic [ADDR_W-1:0] ADDR_NONE = 10'h3fc;

    clk_gate_ctrl DUT (
        .core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
        .pslverr_out(pslverr), .protected_write_unlock_in(unlock), .slow_periph_tick_in(slow_tick),
        .wd_expire_in(wd_exp), .fast_periph_tick_out(fast), .evmgr_a_clk_out(ev_a),
        .evmgr_b_clk_out(ev_b), .converter_clk_out(conv), .serial_periph_clk_out(spi),
        .async_serial_a_clk_out(sa), .async_serial_b_clk_out(sb), .buffered_port_clk_out(bp),
        .can_ctrl_clk_out(can), .wd_disable_unlock_out(wd_unl), .wd_reset_out(wd_rst), .wd_irq_out(wd_irq));

    // 40 MHz system clock
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Single comparison point; case inequality so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        // Bounded wait; the watchdog also guards the whole run
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t bus transfer got no ready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check({31'h0, err}, {31'h0, e}, "write error flag");
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        check(rd, exp, "read data");
        check({31'h0, err}, {31'h0, e}, "read error flag");
    endtask

    // Settle, then count ticks per output; slow ticks every 4 cycles, stopped early so all land
    task automatic window(input logic slow);
        cnt = '{default: 0};
        repeat (12) @(posedge clk);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            slow_tick <= slow && (i % 4 == 0) && (i < 20);
            #1;
            cnt[0] += fast; cnt[1] += ev_a; cnt[2] += ev_b; cnt[3] += conv; cnt[4] += spi;
            cnt[5] += sa; cnt[6] += sb; cnt[7] += bp; cnt[8] += can;
        end
    endtask

    // Expiry pulse, then the routed output one cycle later
    task automatic wd_pulse(input logic irq_exp);
        @(posedge clk);
        wd_exp <= 1'b1;
        @(posedge clk);
        wd_exp <= 1'b0;
        #1;
        check({31'h0, wd_irq}, {31'h0, irq_exp}, "watchdog irq out");
        check({31'h0, wd_rst}, {31'h0, ~irq_exp}, "watchdog reset out");
    endtask

    // Reset held 9 cycles; unlock flag must already read set during reset
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check({30'h0, wd_unl, can}, 32'h2, "outputs in reset");
        @(posedge clk);
        rstn <= 1'b1;
    endtask

    task automatic t_reset();
        rd_chk(ADDR_PERIPH, 32'h0, 1'b0);
        rd_chk(ADDR_SYSCTL, 32'h1, 1'b0);
        rd_chk(ADDR_PRESC, 32'h1, 1'b0);
        window(1'b1);
        check(cnt[0], 12, "fast tick at half rate");
        check(cnt[1] + cnt[2] + cnt[3] + cnt[4] + cnt[5] + cnt[6] + cnt[7] + cnt[8], 0, "gates off");
    endtask

    // Sparse mask first, so a swapped bit shows; then all ones against the reserved mask
    task automatic t_gates();
        wr_chk(ADDR_PERIPH, 32'h4909, 1'b0);
        rd_chk(ADDR_PERIPH, 32'h4909, 1'b0);
        window(1'b1);
        check(cnt[1], cnt[0], "evmgr a");
        check(cnt[2], 0, "evmgr b off");
        check(cnt[3], cnt[0], "converter");
        check(cnt[4], 5, "serial periph");
        check(cnt[5], 0, "async a off");
        check(cnt[6], 5, "async b");
        check(cnt[7], 0, "buffered port off");
        check(cnt[8], 24, "can enable level");
        wr_chk(ADDR_PERIPH, 32'hffffffff, 1'b0);
        rd_chk(ADDR_PERIPH, 32'h5d0b, 1'b0);
        window(1'b1);
        check(cnt[2], cnt[0], "evmgr b on");
        check(cnt[5], 5, "async a on");
        check(cnt[7], 5, "buffered port on");
        wr_chk(ADDR_PERIPH, 32'h0, 1'b0);
        window(1'b1);
        check(cnt[1] + cnt[4] + cnt[6] + cnt[8], 0, "gates cleared by software");
    endtask

    task automatic t_presc();
        wr_chk(ADDR_PRESC, 32'hfffffffb, 1'b0);
        rd_chk(ADDR_PRESC, 32'h3, 1'b0);
        window(1'b0);
        check(cnt[0], 4, "divide by six");
        wr_chk(ADDR_PRESC, 32'h0, 1'b0);
        window(1'b0);
        check(cnt[0], 24, "code zero passes");
        wr_chk(ADDR_PRESC, 32'h1, 1'b0);
        window(1'b0);
        check(cnt[0], 12, "divide by two");
    endtask

    task automatic t_wd();
        wd_pulse(1'b0);
        wr_chk(ADDR_SYSCTL, 32'h2, 1'b0);
        rd_chk(ADDR_SYSCTL, 32'h3, 1'b0);
        wd_pulse(1'b1);
        wr_chk(ADDR_SYSCTL, 32'h3, 1'b0);
        rd_chk(ADDR_SYSCTL, 32'h2, 1'b0);
        check({31'h0, wd_unl}, 32'h0, "unlock out cleared");
        wr_chk(ADDR_SYSCTL, 32'h0, 1'b0);
        rd_chk(ADDR_SYSCTL, 32'h0, 1'b0);
    endtask

    // Lock refusal and an unmapped address
    task automatic t_refuse();
        wr_chk(ADDR_PERIPH, 32'h1, 1'b0);
        @(posedge clk);
        unlock <= 1'b0;
        wr_chk(ADDR_PERIPH, 32'h0, 1'b1);
        rd_chk(ADDR_PERIPH, 32'h1, 1'b0);
        @(posedge clk);
        unlock <= 1'b1;
        rd_chk(ADDR_NONE, 32'h0, 1'b1);
        wr_chk(ADDR_NONE, 32'h1, 1'b1);
    endtask

    task automatic summarize();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        errors = 0; comparisons = 0;
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        unlock = 1'b1; slow_tick = 1'b0; wd_exp = 1'b0;
        do_reset();
        t_reset();
        t_gates();
        t_presc();
        t_wd();
        t_refuse();
        // Second reset must restore the unlock flag
        do_reset();
        rd_chk(ADDR_SYSCTL, 32'h1, 1'b0);
        rd_chk(ADDR_PERIPH, 32'h0, 1'b0);
        summarize();
    end

    // Hang guard, well past the expected run of about 380 cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t run did not complete", $time);
        summarize();
    end
endmodule
